// File: rtl/serial_lane_cfg_pkg.sv
package serial_lane_cfg_pkg;

	localparam int NUM_LANES = 8;
	localparam int LANE_DATA_W = 16;
	localparam int REG_ADDR_W = 12;
	localparam int REG_DATA_W = 8;
	localparam int FIELD_W = 2;
	localparam int LANES_PER_REG = 4;

	// Register offsets
	localparam logic [11:0] OFS_TARGET_INDEX = 12'h210;
	localparam logic [11:0] OFS_LANE_COMMIT = 12'h212;
	localparam logic [11:0] OFS_OTHER_COMMIT = 12'h213;
	localparam logic [11:0] OFS_WRITE_VALUE = 12'h216;
	localparam logic [11:0] OFS_POLARITY = 12'h234;
	localparam logic [11:0] OFS_BOOST_LOW = 12'h240;
	localparam logic [11:0] OFS_BOOST_HIGH = 12'h241;
	localparam logic [11:0] OFS_GAIN_LOW = 12'h242;

	// Reset values
	localparam logic [7:0] RST_TARGET_INDEX = 8'h00;
	localparam logic [7:0] RST_LANE_COMMIT = 8'h00;
	localparam logic [7:0] RST_OTHER_COMMIT = 8'h00;
	localparam logic [7:0] RST_WRITE_VALUE = 8'h00;
	localparam logic [7:0] RST_POLARITY = 8'h66;
	localparam logic [1:0] RST_FIELD = 2'h3;
	localparam logic [7:0] RST_BOOST = 8'hFF;
	localparam logic [7:0] RST_GAIN = 8'hF0;

	// Field layout
	localparam int OTHER_COMMIT_BIT = 0;
	localparam logic [7:0] OTHER_COMMIT_MASK = 8'h01;
	localparam logic [7:0] GAIN_IMPL_MASK = 8'hF0;
	localparam int GAIN_LANE2_LSB = 4;
	localparam int GAIN_LANE3_LSB = 6;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// Field codes for software
	localparam logic [1:0] BOOST_LOW_LOSS = 2'h2;
	localparam logic [1:0] BOOST_HIGH_LOSS = 2'h3;
	localparam logic [1:0] GAIN_LOW_LOSS = 2'h1;
	localparam logic [1:0] GAIN_HIGH_LOSS = 2'h3;

	typedef logic [LANE_DATA_W-1:0] lane_word_t;
	typedef logic [NUM_LANES-1:0][LANE_DATA_W-1:0] lane_bus_t;
	typedef logic [NUM_LANES-1:0][FIELD_W-1:0] lane_field_t;

	typedef struct packed {
		logic [7:0] target_index;
		logic [7:0] value;
		logic [7:0] lane_mask;
		logic other;
	} cfg_cmd_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [REG_ADDR_W-1:0] addr;
		logic [REG_DATA_W-1:0] wdata;
	} reg_req_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ISSUE = 2'b01
	} commit_state_e;

endpackage

// File: rtl/lane_polarity_invert.sv
`timescale 1ns/10ps
`default_nettype none
module lane_polarity_invert
	import serial_lane_cfg_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic [NUM_LANES-1:0] i_invert,
	input wire logic [NUM_LANES-1:0] i_valid,
	input wire lane_bus_t i_lane_data,
	output logic [NUM_LANES-1:0] o_valid,
	output lane_bus_t o_lane_data
);

	lane_bus_t next_lane_data;

	genvar g;
	generate
		for (g = 0; g < NUM_LANES; g++) begin : g_lane
			// Whole word flips; a 0 bit passes data unchanged
			assign next_lane_data[g] = i_invert[g] ?
				~i_lane_data[g] : i_lane_data[g];
		end
	endgenerate

	// One flop process for the whole bus keeps a single writer per variable
	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_lane_data <= '0;
			o_valid <= '0;
		end else begin
			o_lane_data <= next_lane_data;
			o_valid <= i_valid;
		end
	end

endmodule
`default_nettype wire

// File: rtl/serial_lane_phy_config_regs.sv
// Overview of operation
// - Lane strobe write, or other strobe write with bit 0 set, commits staged config while no command is pending
// - Eight-bit staged value register, resets to zero
// - Eight-bit target index register, resets to zero
// - Polarity bit set inverts that lane's data
// - Polarity register resets to 0x66
// - Lanes 0-3 boost in two-bit fields
// - Lanes 4-7 boost in second register
// - Boost fields reset to 3, software picks code
// - Gain lanes 3 and 2 in top fields
`timescale 1ns/10ps
`default_nettype none
module serial_lane_phy_config_regs
	import serial_lane_cfg_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [REG_ADDR_W-1:0] i_reg_addr,
	input wire logic [REG_DATA_W-1:0] i_reg_wdata,
	output logic [REG_DATA_W-1:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output cfg_cmd_s o_cfg_cmd,
	output logic o_cfg_valid,
	input wire logic i_cfg_ready,
	output logic o_cfg_busy,
	output lane_field_t o_lane_boost,
	output logic [FIELD_W-1:0] o_lane2_gain,
	output logic [FIELD_W-1:0] o_lane3_gain,
	output logic [NUM_LANES-1:0] o_lane_invert_select,
	input wire logic [NUM_LANES-1:0] i_lane_valid,
	input wire lane_bus_t i_lane_data,
	output logic [NUM_LANES-1:0] o_lane_valid,
	output lane_bus_t o_lane_data
);

	reg_req_s req;
	logic [7:0] indirect_target_index;
	logic [7:0] lane_commit_strobe;
	logic other_commit_strobe;
	logic [7:0] staged_config_value;
	logic [7:0] lane_invert_select;
	logic [7:0] boost_low;
	logic [7:0] boost_high;
	logic [7:0] gain_low;
	commit_state_e state;
	commit_state_e next_state;
	cfg_cmd_s next_cmd;

	assign req.wr = i_reg_wr;
	assign req.rd = i_reg_rd;
	assign req.addr = i_reg_addr;
	assign req.wdata = i_reg_wdata;

	// Address decode
	wire hit_index = req.addr == OFS_TARGET_INDEX;
	wire hit_lane_commit = req.addr == OFS_LANE_COMMIT;
	wire hit_other_commit = req.addr == OFS_OTHER_COMMIT;
	wire hit_value = req.addr == OFS_WRITE_VALUE;
	wire hit_polarity = req.addr == OFS_POLARITY;
	wire hit_boost_low = req.addr == OFS_BOOST_LOW;
	wire hit_boost_high = req.addr == OFS_BOOST_HIGH;
	wire hit_gain_low = req.addr == OFS_GAIN_LOW;

	wire wr_index = req.wr && hit_index;
	wire wr_lane_commit = req.wr && hit_lane_commit;
	wire wr_other_commit = req.wr && hit_other_commit;
	wire wr_value = req.wr && hit_value;
	wire wr_polarity = req.wr && hit_polarity;
	wire wr_boost_low = req.wr && hit_boost_low;
	wire wr_boost_high = req.wr && hit_boost_high;
	wire wr_gain_low = req.wr && hit_gain_low;

	// Any write of the lane strobe commits; the other strobe needs bit 0
	wire other_go = wr_other_commit && req.wdata[OTHER_COMMIT_BIT];
	wire commit_req = wr_lane_commit || other_go;
	// A strobe while a command is still pending is dropped, not queued
	wire commit_take = commit_req && (state == ST_IDLE);

	// Commit uses the staged values as they stand in this cycle
	assign next_cmd.target_index = indirect_target_index;
	assign next_cmd.value = staged_config_value;
	assign next_cmd.lane_mask = wr_lane_commit ? req.wdata : 8'h00;
	assign next_cmd.other = other_go;

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (commit_take) begin
					next_state = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				if (i_cfg_ready) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_cfg_cmd <= '0;
		end else if (commit_take) begin
			o_cfg_cmd <= next_cmd;
		end
	end

	assign o_cfg_valid = state == ST_ISSUE;
	assign o_cfg_busy = state != ST_IDLE;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			indirect_target_index <= RST_TARGET_INDEX;
			staged_config_value <= RST_WRITE_VALUE;
		end else begin
			if (wr_index) begin
				indirect_target_index <= req.wdata;
			end
			if (wr_value) begin
				staged_config_value <= req.wdata;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			lane_commit_strobe <= RST_LANE_COMMIT;
			other_commit_strobe <= RST_OTHER_COMMIT[OTHER_COMMIT_BIT];
		end else begin
			if (wr_lane_commit) begin
				lane_commit_strobe <= req.wdata;
			end
			if (wr_other_commit) begin
				other_commit_strobe <= req.wdata[OTHER_COMMIT_BIT];
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			lane_invert_select <= RST_POLARITY;
		end else if (wr_polarity) begin
			lane_invert_select <= req.wdata;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			boost_low <= RST_BOOST;
			boost_high <= RST_BOOST;
			gain_low <= RST_GAIN;
		end else begin
			if (wr_boost_low) begin
				boost_low <= req.wdata;
			end
			if (wr_boost_high) begin
				boost_high <= req.wdata;
			end
			if (wr_gain_low) begin
				// Lanes 0 and 1 gain are not held here
				gain_low <= req.wdata & GAIN_IMPL_MASK;
			end
		end
	end

	// Lane n sits in bits 2m+1:2m of its register, with m = n mod 4
	genvar g;
	generate
		for (g = 0; g < LANES_PER_REG; g++) begin : g_boost
			assign o_lane_boost[g] =
				boost_low[g*FIELD_W +: FIELD_W];
			assign o_lane_boost[g+LANES_PER_REG] =
				boost_high[g*FIELD_W +: FIELD_W];
		end
	endgenerate

	assign o_lane2_gain = gain_low[GAIN_LANE2_LSB +: FIELD_W];
	assign o_lane3_gain = gain_low[GAIN_LANE3_LSB +: FIELD_W];
	assign o_lane_invert_select = lane_invert_select;

	// Read mux; unmapped addresses read zero
	wire [7:0] other_rd = {7'h00, other_commit_strobe};
	wire [7:0] rd_mux =
		hit_index ? indirect_target_index :
		hit_lane_commit ? lane_commit_strobe :
		hit_other_commit ? (other_rd & OTHER_COMMIT_MASK) :
		hit_value ? staged_config_value :
		hit_polarity ? lane_invert_select :
		hit_boost_low ? boost_low :
		hit_boost_high ? boost_high :
		hit_gain_low ? gain_low :
		READ_ZERO;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			o_reg_rdata <= READ_ZERO;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= req.rd;
			if (req.rd) begin
				o_reg_rdata <= rd_mux;
			end
		end
	end

	lane_polarity_invert u_invert (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_invert(lane_invert_select),
		.i_valid(i_lane_valid),
		.i_lane_data(i_lane_data),
		.o_valid(o_lane_valid),
		.o_lane_data(o_lane_data)
	);

endmodule
`default_nettype wire

// File: bench/serial_lane_phy_config_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module lane_cfg_checker
	import serial_lane_cfg_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [REG_ADDR_W-1:0] i_reg_addr,
	input wire logic [REG_DATA_W-1:0] i_reg_wdata,
	input wire logic o_reg_rvalid,
	input wire cfg_cmd_s o_cfg_cmd,
	input wire logic o_cfg_valid,
	input wire logic i_cfg_ready,
	input wire logic o_cfg_busy,
	input wire logic [NUM_LANES-1:0] o_lane_invert_select,
	input wire logic [NUM_LANES-1:0] i_lane_valid,
	input wire lane_bus_t i_lane_data,
	input wire logic [NUM_LANES-1:0] o_lane_valid,
	input wire lane_bus_t o_lane_data
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	// A strobe only counts while no command is pending
	sequence strobe(a, d);
		i_reg_wr && !o_cfg_busy && i_reg_addr == a && d;
	endsequence
	sequence stall;
		o_cfg_valid && !i_cfg_ready;
	endsequence
	lane_commit_a: assert property (strobe(OFS_LANE_COMMIT, 1'b1) |=>
		o_cfg_valid && o_cfg_cmd.lane_mask == $past(i_reg_wdata) && !o_cfg_cmd.other)
		else $error("lane commit not issued");
	other_commit_a: assert property (strobe(OFS_OTHER_COMMIT, i_reg_wdata[0]) |=>
		o_cfg_valid && o_cfg_cmd.other && o_cfg_cmd.lane_mask == 8'h00)
		else $error("other commit not issued");
	no_commit_a: assert property (strobe(OFS_OTHER_COMMIT, !i_reg_wdata[0]) |=>
		!o_cfg_valid) else $error("commit without bit 0");
	cmd_hold_a: assert property (stall |=> o_cfg_valid && $stable(o_cfg_cmd))
		else $error("command changed while pending");
	cmd_drop_a: assert property (o_cfg_valid && i_cfg_ready |=> !o_cfg_valid)
		else $error("command not retired");
	busy_release_a: assert property ($fell(o_cfg_busy) |->
		$past(o_cfg_valid && i_cfg_ready))
		else $error("busy dropped without accept");
	read_answer_a: assert property (o_reg_rvalid == $past(i_reg_rd))
		else $error("read answer wrong");
	polarity_reset_a: assert property ($rose(i_rstn) |-> o_lane_invert_select == 8'h66)
		else $error("polarity reset value wrong");
	for (genvar k = 0; k < NUM_LANES; k++) begin : g_lane
		lane_inv_a: assert property (i_lane_valid[k] |=> o_lane_valid[k] &&
			o_lane_data[k] == ($past(i_lane_data[k]) ^ {LANE_DATA_W{$past(o_lane_invert_select[k])}}))
			else $error("lane polarity wrong");
	end
endmodule
bind serial_lane_phy_config_regs lane_cfg_checker u_chk (.i_clk_sys, .i_rstn,
	.i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rvalid, .o_cfg_cmd,
	.o_cfg_valid, .i_cfg_ready, .o_cfg_busy, .o_lane_invert_select, .i_lane_valid,
	.i_lane_data, .o_lane_valid, .o_lane_data);
`default_nettype wire

// File: bench/tb_serial_lane_phy_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_serial_lane_phy_config_regs
	import serial_lane_cfg_pkg::*;
;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, rdy = 0, rv, cv, busy;
	logic [11:0] addr = 0;
	logic [7:0] wd = 0, lv = 0, ov, sel, rdat, x, y, z;
	logic [1:0] g2, g3;
	lane_bus_t ld = '0, od;
	lane_field_t bst;
	cfg_cmd_s cmd;
	integer seed = 33, n_errors = 0, comparisons = 0, cyc = 0;
	logic [7:0] qr[$];
	cfg_cmd_s qc[$];
	lane_bus_t ql[$];
	logic [11:0] ra[9] = '{12'h210, 12'h211, 12'h212, 12'h213, 12'h216,
		12'h234, 12'h240, 12'h241, 12'h242};
	logic [7:0] re[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h66, 8'hFF,
		8'hFF, 8'hF0};
	serial_lane_phy_config_regs u_dut (.i_clk_sys(clk), .i_rstn(rstn),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
		.o_reg_rdata(rdat), .o_reg_rvalid(rv), .o_cfg_cmd(cmd), .o_cfg_valid(cv),
		.i_cfg_ready(rdy), .o_cfg_busy(busy), .o_lane_boost(bst),
		.o_lane2_gain(g2), .o_lane3_gain(g3), .o_lane_invert_select(sel),
		.i_lane_valid(lv), .i_lane_data(ld), .o_lane_valid(ov), .o_lane_data(od));
	always #12.5 clk = ~clk;
	task automatic finish_test();
		if (n_errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk8(logic [7:0] g, logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %0t byte %h exp %h", $time, g, e);
		end
	endtask
	task automatic chkc(cfg_cmd_s g, cfg_cmd_s e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %0t command %h exp %h", $time, g, e);
		end
	endtask
	task automatic chkl(lane_bus_t g, lane_bus_t e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %0t lane data %h exp %h", $time, g, e);
		end
	endtask
	task automatic wreg(logic [11:0] a, logic [7:0] d);
		@(negedge clk);
		wr = 1;
		addr = a;
		wd = d;
		@(negedge clk);
		wr = 0;
	endtask
	task automatic rreg(logic [11:0] a, logic [7:0] e);
		@(negedge clk);
		rd = 1;
		addr = a;
		qr.push_back(e);
		@(negedge clk);
		rd = 0;
	endtask
	// Expected words use the mask the bench believes is loaded
	task automatic lanes(logic [7:0] m);
		lane_bus_t e;
		repeat (10) begin
			@(negedge clk);
			lv = 8'hFF;
			ld = {$random(seed), $random(seed), $random(seed), $random(seed)};
			for (int k = 0; k < 8; k++) e[k] = ld[k] ^ {16{m[k]}};
			ql.push_back(e);
		end
		@(negedge clk);
		lv = 0;
	endtask
	always @(posedge clk) begin
		if (rv) chk8(rdat, qr.pop_front());
		if (cv && rdy) chkc(cmd, qc.pop_front());
		if (ov != 0) chkl(od, ql.pop_front());
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		rstn = 1;
		foreach (ra[i]) rreg(ra[i], re[i]);
		lanes(8'h66);
		repeat (6) begin
			x = 8'($random(seed));
			// Software only picks the documented loss codes per field
			y = x | 8'hAA;
			z = ~x | 8'hAA;
			wreg(12'h240, y);
			wreg(12'h241, z);
			wreg(12'h242, x | 8'h50);
			wreg(12'h210, x);
			wreg(12'h216, ~x);
			chk8(bst[3:0], y);
			chk8(bst[7:4], z);
			chk8({g3, g2, 4'h0}, (x | 8'h50) & 8'hF0);
			rreg(12'h242, (x | 8'h50) & 8'hF0);
			rreg(12'h241, z);
			rreg(12'h240, y);
			rreg(12'h210, x);
			rreg(12'h216, ~x);
		end
		x = 8'($random(seed));
		wreg(12'h210, x);
		wreg(12'h216, 8'hA5);
		qc.push_back(cfg_cmd_s'{x, 8'hA5, 8'h3C, 1'b0});
		wreg(12'h212, 8'h3C);
		wreg(12'h212, 8'h11);
		rreg(12'h212, 8'h11);
		@(negedge clk);
		rdy = 1;
		@(negedge clk);
		rdy = 0;
		wreg(12'h213, 8'h00);
		chk8({7'h0, cv}, 8'h00);
		qc.push_back(cfg_cmd_s'{x, 8'hA5, 8'h00, 1'b1});
		wreg(12'h213, 8'hFF);
		rreg(12'h213, 8'h01);
		rdy = 1;
		x = 8'($random(seed));
		wreg(12'h234, x);
		chk8(sel, x);
		lanes(x);
		repeat (3) @(negedge clk);
		chk8(8'(qr.size() + qc.size() + ql.size()), 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
